//--- bench/ccf_ctrl_bench.sv
/* Self-checking bench of the command FIFO controller.
 * Assumes the host model drives the bus; bench plays the core. */
`timescale 1ns/1ns
module ccf_ctrl_bench;
    import ccf_pkg::*;
    logic hclk = 0, hresetn = 0, cmd_ready = 0, gen_valid = 0, cop_error = 0;
    logic [31:0] gen_data = 32'h0, q;
    wire hsel, hwrite, hung, hreadyout, hresp, cmd_valid, dl_we, eir, irq;
    wire [1:0] htrans;
    wire [2:0] hsize;
    wire [12:0] dl_addr;
    wire [31:0] haddr, hwdata, hrdata, cmd_data, dl_wdata;
    int errors = 0, cmp_count = 0;
    always #5 hclk = ~hclk;
    ccf_host_model u_ccf_host_model (.hclk, .hready(hreadyout), .hrdata,
        .hsel, .hwrite, .hung, .htrans, .hsize, .haddr, .hwdata);
    ccf_ctrl u_ccf_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .cmd_valid, .cmd_data, .cmd_ready, .gen_valid, .gen_data, .cop_error,
        .dl_we, .dl_addr, .dl_wdata, .engine_in_reset(eir), .irq);
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task rc(input logic [11:0] a, input logic [31:0] e);
        u_ccf_host_model.rd(a, q);
        chk(q, e);
    endtask
    // Poll with a bound; running out shows as a mismatch
    task waitq(input logic [11:0] a, input logic [31:0] e);
        u_ccf_host_model.rd(a, q);
        for (int n = 0; n < 4000 && q !== e; n++) u_ccf_host_model.rd(a, q);
        chk(q, e);
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge hung) begin errors++; conclude(); end
    task t_reset;
        rc(CCF_OFF_CMD_READ, 32'h0);
        rc(CCF_OFF_DL_OFFSET, 32'h0);
        rc(CCF_OFF_RESET_CTRL, 32'h0);
        u_ccf_host_model.wr(CCF_OFF_FREE_SPACE, 32'h0);
        rc(CCF_OFF_FREE_SPACE, 32'hFFC);
        rc(12'h004, 32'h0);
        $display("done reset values");
    endtask
    task t_fetch;
        rc(CCF_OFF_FREE_SPACE, 32'hFFC);
        for (int i = 0; i < 3; i++) u_ccf_host_model.wr(CCF_OFF_BULK_PORT,
            32'hC0DE0000 + i);
        rc(CCF_OFF_CMD_WRITE, 32'hC);
        rc(CCF_OFF_FREE_SPACE, 32'hFF0);
        @(negedge hclk) chk({31'h0, cmd_valid}, 32'h1);
        chk(cmd_data, 32'hC0DE0000);
        u_ccf_host_model.wr(CCF_OFF_IRQ_MASK, 32'h2);
        cmd_ready <= 1'b1;
        waitq(CCF_OFF_CMD_READ, 32'hC);
        rc(CCF_OFF_FREE_SPACE, 32'hFFC);
        @(negedge hclk) chk({31'h0, irq}, 32'h1);
        rc(CCF_OFF_IRQ_STATUS, 32'h2);
        @(negedge hclk) chk({31'h0, irq}, 32'h0);
        $display("done fetch");
    endtask
    task t_wrap;
        u_ccf_host_model.wr(CCF_OFF_CMD_WRITE, 32'hFF8);
        waitq(CCF_OFF_CMD_READ, 32'hFF8);
        for (int i = 0; i < 3; i++) u_ccf_host_model.wr(CCF_OFF_BULK_PORT,
            32'hBEEF0000 + i);
        waitq(CCF_OFF_CMD_READ, 32'h4);
        @(negedge hclk) chk(cmd_data, 32'hBEEF0002);
        rc(CCF_OFF_CMD_WRITE, 32'h4);
        rc(CCF_OFF_FREE_SPACE, 32'hFFC);
        rc(CCF_OFF_IRQ_STATUS, 32'h2);
        $display("done wrap");
    endtask
    task t_gen;
        u_ccf_host_model.wr(CCF_OFF_DL_OFFSET, 32'h1FFC);
        @(posedge hclk);
        gen_valid <= 1'b1;
        gen_data <= 32'hA5A5A5A5;
        @(posedge hclk) gen_data <= 32'h5A5A5A5A;
        @(negedge hclk) chk({19'h0, dl_addr}, 32'h1FFC);
        chk(dl_wdata, 32'hA5A5A5A5);
        chk({31'h0, dl_we}, 32'h1);
        @(posedge hclk) gen_valid <= 1'b0;
        @(negedge hclk) chk({19'h0, dl_addr}, 32'h0);
        chk(dl_wdata, 32'h5A5A5A5A);
        rc(CCF_OFF_DL_OFFSET, 32'h4);
        $display("done generate");
    endtask
    task t_error;
        u_ccf_host_model.wr(CCF_OFF_IRQ_MASK, 32'h1);
        @(posedge hclk) cop_error <= 1'b1;
        @(posedge hclk) cop_error <= 1'b0;
        rc(CCF_OFF_CMD_READ, 32'hFFF);
        @(negedge hclk) chk({31'h0, irq}, 32'h1);
        rc(CCF_OFF_IRQ_STATUS, 32'h1);
        u_ccf_host_model.wr(CCF_OFF_CMD_READ, 32'h4);
        rc(CCF_OFF_CMD_READ, 32'h4);
        u_ccf_host_model.wr(CCF_OFF_RESET_CTRL, 32'h1);
        rc(CCF_OFF_RESET_CTRL, 32'h1);
        chk({31'h0, eir}, 32'h1);
        rc(CCF_OFF_CMD_READ, 32'h0);
        u_ccf_host_model.wr(CCF_OFF_RESET_CTRL, 32'h0);
        rc(CCF_OFF_RESET_CTRL, 32'h0);
        rc(CCF_OFF_FREE_SPACE, 32'hFFC);
        $display("done error recovery");
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_fetch();
        t_wrap();
        t_gen();
        t_error();
        conclude();
    end
endmodule

//--- bench/ccf_ctrl_sva.sv
/* Checker for the command FIFO controller ports.
 * Assumes one clock, hresetn asynchronous and active low. */
`timescale 1ns/1ns
module ccf_ctrl_sva #(
    parameter int MEM_WORDS = 1024 // Ring depth, handed on
) (
    input wire logic hclk, hresetn, hsel, hready, hreadyout, hresp, // Bus
    input wire logic [1:0] htrans, // Transfer type
    input wire logic [31:0] hrdata, cmd_data, gen_data, dl_wdata, // Data
    input wire logic cmd_valid, cmd_ready, gen_valid, cop_error, // Core
    input wire logic dl_we, engine_in_reset // Outputs to core side
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Zero wait states keep the master's bounded waits short
    a_resp_okay: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or errored");
    a_rdata_hold: assert property (!(hsel && htrans[1] && hready)
        |=> $stable(hrdata)) else $error("read data moved");
    a_gen_write: assert property (gen_valid && !engine_in_reset
        |=> dl_we && dl_wdata == $past(gen_data))
        else $error("generated word not written");
    a_gen_only: assert property (!gen_valid |=> !dl_we)
        else $error("spurious display-list write");
    // A stalled word must not change under the core
    a_cmd_hold: assert property (cmd_valid && !cmd_ready &&
        !cop_error && !engine_in_reset |=> cmd_valid && $stable(cmd_data))
        else $error("fetched word dropped while stalled");
    a_cmd_take: assert property (cmd_valid && cmd_ready
        |=> !cmd_valid) else $error("word held after take");
    a_fetch_gap: assert property ($fell(cmd_valid) |=> !cmd_valid)
        else $error("fetch restarted too soon");
    a_err_stop: assert property (cop_error && !engine_in_reset
        |=> !cmd_valid) else $error("fetch ran on after error");
    a_rst_quiet: assert property (engine_in_reset ##1 engine_in_reset
        |-> !cmd_valid && !dl_we) else $error("engine active in reset");
    c_take: cover property (cmd_valid && cmd_ready);
    c_gen: cover property (dl_we);
    c_rst: cover property (engine_in_reset);
endmodule
bind ccf_ctrl ccf_ctrl_sva #(.MEM_WORDS(MEM_WORDS)) u_sva (.hclk, .hresetn,
    .hsel, .hready, .hreadyout, .hresp, .htrans, .hrdata, .cmd_data,
    .gen_data, .dl_wdata, .cmd_valid, .cmd_ready, .gen_valid, .cop_error,
    .dl_we, .engine_in_reset);

//--- bench/ccf_host_model.sv
/* Host side model: single-word AHB-Lite master tasks.
 * Assumes one slave whose hreadyout is the bus hready. */
`timescale 1ns/1ns
module ccf_host_model (
    input wire logic hclk, // Bus clock
    input wire logic hready, // Bus ready
    input wire logic [31:0] hrdata, // Read data
    output logic hsel, hwrite, hung, // Select, direction, wait ran out
    output logic [1:0] htrans, // Transfer type
    output logic [2:0] hsize, // Always a word
    output logic [31:0] haddr, hwdata // Address and write data
);
    initial begin
        {hsel, hwrite, hung, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
    end
    // Address phase held until ready, then data phase until ready
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        if (hclk !== 1'b1) @(posedge hclk); // Start just after a rise
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 64);
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 128);
        q = hrdata;
        if (n >= 128) hung <= 1'b1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        xfer(a, 1'b0, 32'h0, q);
    endtask
endmodule

//--- logic/ccf_ctrl.sv
/*
 * Command FIFO controller: command ring memory, host write pointer,
 * coprocessor read pointer, free-space report, display-list output
 * offset and engine reset control, all reached over AHB-Lite.
 * Assumes the coprocessor core sits on the same clock, takes fetched
 * words with a valid/ready handshake and reports errors as a pulse.
 */
`timescale 1ns/1ns

// Notes on behaviour
// - display-list offset is 13 bits, 0 to 8191
// - each generated command advances the display-list offset
// - host write sets where generation starts
// - ring is 4096 bytes, four bytes per command
// - read pointer advances on every command fetch
// - on error read pointer becomes 0xFFF
// - engine reset returns read pointer to zero
// - free space reads 0xFFC after reset
// - bulk port write appends word to ring
// - reset control bit 0 holds engine in reset
module ccf_ctrl
    import ccf_pkg::*;
#(
    parameter int MEM_WORDS = 1024 // Ring depth in 32-bit words
) (
    input wire logic hclk, // System clock, 100 MHz
    input wire logic hresetn, // Asynchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Always ready, zero wait states
    output logic hresp, // Always OKAY
    output logic cmd_valid, // Fetched command word valid
    output logic [31:0] cmd_data, // Fetched command word
    input wire logic cmd_ready, // Core takes the fetched word
    input wire logic gen_valid, // Core emits a generated command
    input wire logic [31:0] gen_data, // Generated command word
    input wire logic cop_error, // Core error pulse
    output logic dl_we, // Display-list memory write strobe
    output logic [12:0] dl_addr, // Display-list byte offset
    output logic [31:0] dl_wdata, // Display-list write data
    output logic engine_in_reset, // Coprocessor core held in reset
    output logic irq // Level interrupt
);

    // Controller state, apart from the ring and its registered read data
    typedef struct packed {
        logic [11:0] rd_ptr; // Coprocessor read pointer
        logic [11:0] wr_ptr; // Host write pointer
        logic [12:0] dl_off; // Display-list output offset
        logic eng_rst; // Engine reset control bit
        logic [1:0] irq_stat; // Sticky event bits
        logic [1:0] irq_mask; // Interrupt enables
        ccf_fetch_type fetch; // Fetch engine state
        logic [31:0] cmd_word; // Word presented to the core
        logic dph_valid; // Data phase pending
        logic dph_write; // Pending phase is a write
        logic [11:0] dph_addr; // Pending phase offset
        logic [31:0] rdata; // Read data for the bus
        logic dl_we; // Display-list strobe
        logic [12:0] dl_addr; // Display-list address
        logic [31:0] dl_wdata; // Display-list data
    } ccf_state_type;

    ccf_state_type s_q; // Registered state
    ccf_state_type s_d; // Next state
    logic [31:0] mem [MEM_WORDS]; // Command ring, one word per command
    logic [31:0] mem_rdata_q; // Registered ring read data
    logic [11:0] used_bytes; // Bytes waiting in the ring
    logic [11:0] free_bytes; // Bytes the host may still write
    logic addr_take; // Address phase accepted this cycle
    logic bulk_we; // Bulk port word lands in the ring
    logic fetch_rd; // Fetch engine reads the ring

    // Ring occupancy; one word stays unused so full differs from empty.
    // Both pointers are byte counts that wrap at 4096 by their width,
    // so the plain 12-bit difference is already the modulo distance.
    assign used_bytes = s_q.wr_ptr - s_q.rd_ptr;
    // Live value; with the error sentinel loaded it means nothing
    // until the host recovers the read pointer
    assign free_bytes = CCF_FREE_MAX - used_bytes;

    // Address phase seen: NONSEQ or SEQ while the bus is ready.
    // Only single words are expected, so hsize is not checked.
    assign addr_take = hsel & htrans[1] & hready;
    // Writes beyond the free space are dropped, never overwrite unread.
    // The host is expected to poll free space first, so a drop means
    // a host fault and is kept silent rather than raised as an error.
    assign bulk_we = s_q.dph_valid & s_q.dph_write & ~s_q.eng_rst
        & (s_q.dph_addr == CCF_OFF_BULK_PORT)
        & (free_bytes >= CCF_WORD_BYTES);
    // A fetch starts only from idle, with words waiting and no error
    // parked in the read pointer
    assign fetch_rd = (s_q.fetch == CCF_IDLE) & ~s_q.eng_rst
        & (s_q.rd_ptr != s_q.wr_ptr)
        & (s_q.rd_ptr != CCF_ERR_SENTINEL);

    // Ring memory: host fills at the write pointer, engine reads at read.
    // No reset here: contents are only ever read between the pointers,
    // and leaving it out lets the array map onto block memory.
    always_ff @(posedge hclk) begin
        if (bulk_we) begin
            mem[s_q.wr_ptr[11:2]] <= hwdata;
        end
        if (fetch_rd) begin
            mem_rdata_q <= mem[s_q.rd_ptr[11:2]];
        end
    end

    // Next-state logic for bus, pointers, fetch engine and interrupts
    always_comb begin
        // Everything holds unless a branch below moves it
        s_d = s_q;
        // The display-list strobe is a one-cycle pulse
        s_d.dl_we = 1'b0;

        // Address phase: capture, and prepare read data early
        if (addr_take) begin
            s_d.dph_valid = 1'b1;
            s_d.dph_write = hwrite;
            s_d.dph_addr = haddr[11:0];
            s_d.rdata = 32'h0000_0000; // Unmapped reads return zero
            if (!hwrite) begin
                case (haddr[11:0])
                    CCF_OFF_RESET_CTRL: begin
                        s_d.rdata[CCF_ENG_RST_BIT] = s_q.eng_rst;
                    end
                    CCF_OFF_CMD_READ: begin
                        s_d.rdata[11:0] = s_q.rd_ptr;
                    end
                    CCF_OFF_CMD_WRITE: begin
                        s_d.rdata[11:0] = s_q.wr_ptr;
                    end
                    CCF_OFF_DL_OFFSET: begin
                        s_d.rdata[12:0] = s_q.dl_off;
                    end
                    CCF_OFF_FREE_SPACE: begin
                        s_d.rdata[11:0] = free_bytes;
                    end
                    CCF_OFF_IRQ_STATUS: begin
                        s_d.rdata[1:0] = s_q.irq_stat;
                        // Events set later in this process still win
                        s_d.irq_stat = 2'h0; // Read clears
                    end
                    CCF_OFF_IRQ_MASK: begin
                        s_d.rdata[1:0] = s_q.irq_mask;
                    end
                    default: begin
                        s_d.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end else begin
            // No transfer: the next cycle has no data phase
            s_d.dph_valid = 1'b0;
        end

        // Generated commands go out at the current offset.
        // The 13-bit offset wraps from 8188 back to 0 by its width, so
        // the engine never writes outside display-list memory.
        if (gen_valid && !s_q.eng_rst) begin
            s_d.dl_we = 1'b1;
            s_d.dl_addr = s_q.dl_off;
            s_d.dl_wdata = gen_data;
            s_d.dl_off = s_q.dl_off + CCF_DL_STEP;
        end

        // Fetch engine: read ring, hand word over, then advance.
        // Three states cost cycles per word but keep the ring read
        // registered, which matters more than peak fetch rate here.
        case (s_q.fetch)
            CCF_IDLE: begin
                if (fetch_rd) begin
                    s_d.fetch = CCF_READ;
                end
            end
            CCF_READ: begin
                // Ring data registered at the last edge goes to the core
                s_d.cmd_word = mem_rdata_q;
                s_d.fetch = CCF_OUT;
            end
            CCF_OUT: begin
                if (cmd_ready) begin
                    s_d.rd_ptr = s_q.rd_ptr + CCF_WORD_BYTES;
                    s_d.fetch = CCF_IDLE;
                    // Last waiting word taken: flag the ring as drained
                    if (s_q.rd_ptr + CCF_WORD_BYTES == s_q.wr_ptr) begin
                        s_d.irq_stat[CCF_IRQ_DRAIN_BIT] = 1'b1;
                    end
                end
            end
            default: begin
                s_d.fetch = CCF_IDLE;
            end
        endcase

        // Data phase: register writes; host choices win over engine moves.
        // Coming after the engine code, a host write of a pointer or of
        // the offset overrides whatever the engine did in the same cycle.
        if (s_q.dph_valid && s_q.dph_write) begin
            case (s_q.dph_addr)
                CCF_OFF_RESET_CTRL: begin
                    s_d.eng_rst = hwdata[CCF_ENG_RST_BIT];
                end
                CCF_OFF_CMD_READ: begin
                    // Recovery path only; a stalled fetch restarts clean
                    s_d.rd_ptr = hwdata[11:0];
                    s_d.fetch = CCF_IDLE;
                end
                CCF_OFF_CMD_WRITE: begin
                    s_d.wr_ptr = hwdata[11:0];
                end
                CCF_OFF_DL_OFFSET: begin
                    s_d.dl_off = hwdata[12:0];
                end
                CCF_OFF_BULK_PORT: begin
                    if (bulk_we) begin
                        s_d.wr_ptr = s_q.wr_ptr + CCF_WORD_BYTES;
                    end
                end
                CCF_OFF_IRQ_MASK: begin
                    s_d.irq_mask = hwdata[1:0];
                end
                default: begin
                    s_d.dph_addr = s_q.dph_addr; // Ignored, still OKAY
                end
            endcase
        end

        // Error loads the sentinel and stops fetching until recovery.
        // It follows the host writes, so an error beats a recovery write.
        if (cop_error && !s_q.eng_rst) begin
            s_d.rd_ptr = CCF_ERR_SENTINEL;
            s_d.fetch = CCF_IDLE;
            s_d.irq_stat[CCF_IRQ_ERROR_BIT] = 1'b1; // Set beats read clear
        end

        // Engine reset empties the ring and parks every pointer.
        // Last in the process, so it beats host writes and engine moves;
        // pointer writes made while the bit is set are lost.
        if (s_q.eng_rst) begin
            s_d.rd_ptr = CCF_PTR_RESET;
            s_d.wr_ptr = CCF_PTR_RESET;
            s_d.dl_off = CCF_DL_RESET;
            s_d.fetch = CCF_IDLE;
        end
    end

    // State register; the reset branch loads constants only.
    // The ring array has no reset, see the memory process above.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q.rd_ptr <= CCF_PTR_RESET;
            s_q.wr_ptr <= CCF_PTR_RESET;
            s_q.dl_off <= CCF_DL_RESET;
            s_q.eng_rst <= CCF_ENG_RST_RESET;
            s_q.irq_stat <= CCF_IRQ_RESET;
            s_q.irq_mask <= CCF_IRQ_RESET;
            s_q.fetch <= CCF_IDLE;
            s_q.cmd_word <= 32'h0000_0000;
            s_q.dph_valid <= 1'b0;
            s_q.dph_write <= 1'b0;
            s_q.dph_addr <= 12'h000;
            s_q.rdata <= 32'h0000_0000;
            s_q.dl_we <= 1'b0;
            s_q.dl_addr <= 13'h0000;
            s_q.dl_wdata <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs; data come straight from flip-flops
    assign hrdata = s_q.rdata;
    // Every register answers at once, so no wait state is inserted
    assign hreadyout = 1'b1;
    // No transfer is refused; unmapped addresses read zero
    assign hresp = 1'b0;
    // Valid compares all three one-hot state bits, so it is decoded
    // logic rather than a flip-flop output
    assign cmd_valid = (s_q.fetch == CCF_OUT);
    assign cmd_data = s_q.cmd_word;
    assign dl_we = s_q.dl_we;
    assign dl_addr = s_q.dl_addr;
    assign dl_wdata = s_q.dl_wdata;
    assign engine_in_reset = s_q.eng_rst;
    // Level output: high while an unmasked sticky bit is set
    assign irq = |(s_q.irq_stat & s_q.irq_mask);

endmodule

//--- logic/ccf_pkg.sv
/*
 * Package of the coprocessor command FIFO controller: register offsets,
 * field widths, reset values and the fetch state encoding.
 * Assumes a single 100 MHz clock and a 32-bit AHB-Lite register bus.
 */
package ccf_pkg;
    // Register byte offsets on the bus (low 12 address bits decoded)
    localparam logic [11:0] CCF_OFF_RESET_CTRL = 12'h020;
    localparam logic [11:0] CCF_OFF_CMD_READ = 12'h0F8;
    localparam logic [11:0] CCF_OFF_CMD_WRITE = 12'h0FC;
    localparam logic [11:0] CCF_OFF_DL_OFFSET = 12'h100;
    localparam logic [11:0] CCF_OFF_FREE_SPACE = 12'h574;
    localparam logic [11:0] CCF_OFF_BULK_PORT = 12'h578;
    localparam logic [11:0] CCF_OFF_IRQ_STATUS = 12'h580;
    localparam logic [11:0] CCF_OFF_IRQ_MASK = 12'h584;
    // Field widths and positions
    localparam int CCF_PTR_W = 12;
    localparam int CCF_DL_W = 13;
    localparam int CCF_IRQ_W = 2;
    localparam int CCF_IRQ_ERROR_BIT = 0;
    localparam int CCF_IRQ_DRAIN_BIT = 1;
    localparam int CCF_ENG_RST_BIT = 0;
    // Values
    localparam logic [11:0] CCF_WORD_BYTES = 12'h004;
    localparam logic [12:0] CCF_DL_STEP = 13'h0004;
    localparam logic [11:0] CCF_FREE_MAX = 12'hFFC;
    localparam logic [11:0] CCF_ERR_SENTINEL = 12'hFFF;
    localparam logic [11:0] CCF_PTR_RESET = 12'h000;
    localparam logic [12:0] CCF_DL_RESET = 13'h0000;
    localparam logic [1:0] CCF_IRQ_RESET = 2'h0;
    localparam logic CCF_ENG_RST_RESET = 1'b0;
    // Fetch engine states, one-hot
    typedef enum logic [2:0] {
        CCF_IDLE = 3'b001,
        CCF_READ = 3'b010,
        CCF_OUT = 3'b100
    } ccf_fetch_type;
endpackage
